/* verilog/tiu_cfg.svh */
// Register map, field positions, reset values and counts of the timer and interrupt unit.
// Included by its bare name from the unit's design files; definitions only.
`ifndef TIU_CFG_SVH
`define TIU_CFG_SVH
// Register addresses.
`define TIU_ADR_CTRL 8'h01
`define TIU_ADR_TA_CNT 8'h02
`define TIU_ADR_TA_PSC 8'h03
`define TIU_ADR_TB_CNT 8'h04
`define TIU_ADR_TB_PSC 8'hf3
`define TIU_ADR_IRQ_REQ 8'h06
`define TIU_ADR_IRQ_MASK 8'h07
`define TIU_ADR_IRQ_PRIO 8'h08
// Control register bits.
`define TIU_C_LD_A 0
`define TIU_C_RUN_A 1
`define TIU_C_LD_B 2
`define TIU_C_RUN_B 3
`define TIU_C_TIN_LO 4
`define TIU_C_TIN_HI 5
`define TIU_C_CASC 6
// Prescaler register fields.
`define TIU_PSC_RELOAD 0
`define TIU_PSC_INTCLK 1
`define TIU_PSC_DIV_LO 2
`define TIU_PSC_DIV_HI 7
// Timer input functions.
`define TIU_TIN_CLK 2'h0
`define TIU_TIN_GATE 2'h1
`define TIU_TIN_NTRIG 2'h2
`define TIU_TIN_RTRIG 2'h3
// Interrupt request and mask fields.
`define TIU_NREQ 6
`define TIU_REQ_HI 5
`define TIU_ES_LO 6
`define TIU_ES_HI 7
`define TIU_ES_BOTH 2'h3
`define TIU_MASK_GLB 7
`define TIU_REQ_TA 4
`define TIU_REQ_TB 5
// Reset values and counts.
`define TIU_RST8 8'h00
`define TIU_RST6 6'h00
`define TIU_RST3 3'h0
`define TIU_RST2 2'h0
`define TIU_CNT_LAST 8'h01
`define TIU_PSC_ONE 6'h01
`define TIU_PSC_ZERO 6'h00
`define TIU_DIV4_LAST 2'h3
`define TIU_DIV4_ONE 2'h1
`define TIU_VEC_PAD 12'h000
// Idle levels of the sampled inputs: pins high, side sources low.
`define TIU_IN_IDLE 7'h0f
`endif

/* verilog/tiu_pkg.sv */
// Types shared by the timer and interrupt unit.
// Assumes nothing of its surroundings.
package tiu_pkg;
   // Interrupt cycle sequencer states.
   typedef enum logic [2:0] {TIU_IDLE, TIU_DIS, TIU_SAVE, TIU_HI, TIU_LO, TIU_BR} tiu_state_t;
endpackage

/* verilog/tiu_top.sv */
// Timer and interrupt unit: two 8-bit down-counters with 6-bit prescalers, and a six-source
// vectored, prioritized interrupt controller with its interrupt cycle sequencer.
// Assumes all pin and core inputs are synchronous to ref_clk and the core asks no more than
// one interrupt cycle at a time.
// Notes on behaviour
// - Two independent 8-bit counters, each behind its own 6-bit prescaler.
// - Timer a counts internal clock only; timer b may use an external source.
// - Each prescaler divides its source by 1 to 64.
// - Counter loads an initial count of 1 to 256 steps, one step per tick.
// - End of count raises the timer a or timer b request.
// - Software starts, stops, continues or restarts each counter.
// - Counter either halts at zero or reloads and keeps counting.
// - Counters read back live without disturbance; prescalers read as zero.
// - Timer b source is internal clock divided by four or the timer input pin.
// - Timer input is external clock, retrigger, one-shot trigger or gate.
// - Timer a end of count may clock timer b in cascade.
// - Six maskable prioritized requests: four pins, two timers.
// - Each request takes its documented pin edge and side sources.
// - Mask register holds a global enable and six individual enables.
// - Vectors sit at program bytes 0 to 11, two bytes per request.
// - Programmable priority picks one request among those pending.
// - Grant disables interrupts, saves context, then branches through the vector.
// - Service address is the vector byte and the byte after it.
// - Masked requests still latch in the request register for polling.
// - Request register top bits choose edge sense of two pins.
// - Timers and pin requests keep running while the core is halted.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "tiu_cfg.svh"
module tiu_top (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Request pins and side sources.
   input wire logic pin_rx_irq,
   input wire logic pin_timer_irq,
   input wire logic pin_any_edge_irq,
   input wire logic pin_fall_irq,
   input wire logic port_a_data_avail,
   input wire logic port_c_data_avail,
   input wire logic uart_irq,
   // Core interface.
   input wire logic cpu_int_ok,
   output logic save_ctx,
   output logic pm_rd,
   output logic [15:0] pm_addr,
   input wire logic [7:0] pm_data,
   output logic branch,
   output logic [15:0] branch_addr,
   output logic wake
);

////////////////////////////////////////////////////////////////////////////////////////////////
// Helpers.

   // Prescaler step: returns the tick and the next prescaler value; a field of zero means 64.
   function automatic logic [6:0] tiu_psc(input logic [5:0] p, input logic [5:0] div, input logic src);
      logic [6:0] res;
      begin
         res = {1'b0, p};
         if (src && p == `TIU_PSC_ZERO) begin
            res = {1'b1, div - `TIU_PSC_ONE};
         end else if (src) begin
            res = {1'b0, p - `TIU_PSC_ONE};
         end
         return res;
      end
   endfunction

   // Rotating priority: the first pending request at or after the start index wins.
   function automatic logic [3:0] tiu_pick(input logic [5:0] req, input logic [2:0] start);
      logic [3:0] res;
      integer k;
      integer j;
      begin
         res = 4'h0;
         for (k = `TIU_NREQ - 1; k >= 0; k--) begin
            j = (int'(start) + k) % `TIU_NREQ;
            if (req[j]) begin
               res = {1'b1, 3'(j)};
            end
         end
         return res;
      end
   endfunction

////////////////////////////////////////////////////////////////////////////////////////////////
// Register decode.

   // Write strobes per register.
   wire wr_ctrl = reg_wr && reg_addr == `TIU_ADR_CTRL;
   wire wr_ta_cnt = reg_wr && reg_addr == `TIU_ADR_TA_CNT;
   wire wr_ta_psc = reg_wr && reg_addr == `TIU_ADR_TA_PSC;
   wire wr_tb_cnt = reg_wr && reg_addr == `TIU_ADR_TB_CNT;
   wire wr_tb_psc = reg_wr && reg_addr == `TIU_ADR_TB_PSC;
   wire wr_req = reg_wr && reg_addr == `TIU_ADR_IRQ_REQ;
   wire wr_mask = reg_wr && reg_addr == `TIU_ADR_IRQ_MASK;
   wire wr_prio = reg_wr && reg_addr == `TIU_ADR_IRQ_PRIO;

   logic [7:0] cnt_a_r, cnt_a_nxt, init_a_r, cnt_b_r, cnt_b_nxt, init_b_r, vec_hi_r;
   logic [5:0] psc_a_r, psc_a_nxt, psc_b_r, psc_b_nxt;
   logic [7:0] psc_cfg_a_r, psc_cfg_b_r;
   logic run_a_r, run_a_nxt, run_b_r, run_b_nxt, casc_r;
   logic [1:0] tin_mode_r, es_r, div4_r;
   logic [5:0] pend_r, pend_nxt, mask_r;
   logic glob_en_r, glob_en_nxt;
   logic [2:0] prio_r, idx_r;
   logic [6:0] prev_r;
   tiu_pkg::tiu_state_t state_r, state_nxt;

   // Ctrl reads show live run state and modes; restart bits read zero.
   wire [7:0] ctrl_rd = {1'b0, casc_r, tin_mode_r, run_b_r, 1'b0, run_a_r, 1'b0};
   // Prescaler registers are write only and read as zero; counters read live.
   wire [7:0] rd_mux = (reg_addr == `TIU_ADR_CTRL) ? ctrl_rd :
                       (reg_addr == `TIU_ADR_TA_CNT) ? cnt_a_r :
                       (reg_addr == `TIU_ADR_TB_CNT) ? cnt_b_r :
                       (reg_addr == `TIU_ADR_IRQ_REQ) ? {es_r, pend_r} :
                       (reg_addr == `TIU_ADR_IRQ_MASK) ? {glob_en_r, 1'b0, mask_r} :
                       (reg_addr == `TIU_ADR_IRQ_PRIO) ? {5'h00, prio_r} : `TIU_RST8;

////////////////////////////////////////////////////////////////////////////////////////////////
// Timer clock sources.

   // Internal clock divided by four feeds both prescalers; it runs in halt as well.
   wire div4_w = div4_r == `TIU_DIV4_LAST;
   wire [5:0] div_a = psc_cfg_a_r[`TIU_PSC_DIV_HI:`TIU_PSC_DIV_LO];
   wire [5:0] div_b = psc_cfg_b_r[`TIU_PSC_DIV_HI:`TIU_PSC_DIV_LO];
   // Pin mode is chosen by a cleared bit in the timer b prescaler register.
   wire tin_sel = !psc_cfg_b_r[`TIU_PSC_INTCLK];
   wire tin_fall = prev_r[2] && !pin_timer_irq;
   wire tin_rise = !prev_r[2] && pin_timer_irq;
   // Trigger modes restart timer b on a falling edge; the one-shot form ignores it while running.
   wire trig_b = tin_sel && !casc_r && tin_fall &&
                 (tin_mode_r == `TIU_TIN_RTRIG || (tin_mode_r == `TIU_TIN_NTRIG && !run_b_r));
   // Timer b source: cascade, pin clock, gated internal, or plain internal clock.
   logic eoc_a, eoc_b, tick_a, tick_b;
   wire src_b = casc_r ? eoc_a :
                !tin_sel ? div4_w :
                (tin_mode_r == `TIU_TIN_CLK) ? tin_fall :
                (tin_mode_r == `TIU_TIN_GATE) ? (div4_w && pin_timer_irq) : div4_w;
   wire ld_a = wr_ctrl && reg_wdata[`TIU_C_LD_A];
   wire ld_b = (wr_ctrl && reg_wdata[`TIU_C_LD_B]) || trig_b;

////////////////////////////////////////////////////////////////////////////////////////////////
// Timer a: internal clock only.

   always_comb begin
      {tick_a, psc_a_nxt} = tiu_psc(psc_a_r, div_a, run_a_r && div4_w);
      cnt_a_nxt = cnt_a_r;
      run_a_nxt = run_a_r;
      eoc_a = 1'b0;
      // An initial count of zero runs 256 steps before the end of count.
      if (tick_a && cnt_a_r == `TIU_CNT_LAST) begin
         eoc_a = 1'b1;
         if (psc_cfg_a_r[`TIU_PSC_RELOAD]) begin
            cnt_a_nxt = init_a_r;
         end else begin
            cnt_a_nxt = `TIU_RST8;
            run_a_nxt = 1'b0;
         end
      end else if (tick_a) begin
         cnt_a_nxt = cnt_a_r - `TIU_CNT_LAST;
      end
      // Run bit starts, stops or continues; restart reloads count and prescaler.
      if (wr_ctrl) begin
         run_a_nxt = reg_wdata[`TIU_C_RUN_A];
      end
      if (ld_a) begin
         cnt_a_nxt = init_a_r;
         psc_a_nxt = div_a - `TIU_PSC_ONE;
      end
   end

////////////////////////////////////////////////////////////////////////////////////////////////
// Timer b: internal, pin or cascaded source.

   always_comb begin
      {tick_b, psc_b_nxt} = tiu_psc(psc_b_r, div_b, run_b_r && src_b);
      cnt_b_nxt = cnt_b_r;
      run_b_nxt = run_b_r;
      eoc_b = 1'b0;
      if (tick_b && cnt_b_r == `TIU_CNT_LAST) begin
         eoc_b = 1'b1;
         if (psc_cfg_b_r[`TIU_PSC_RELOAD]) begin
            cnt_b_nxt = init_b_r;
         end else begin
            cnt_b_nxt = `TIU_RST8;
            run_b_nxt = 1'b0;
         end
      end else if (tick_b) begin
         cnt_b_nxt = cnt_b_r - `TIU_CNT_LAST;
      end
      if (wr_ctrl) begin
         run_b_nxt = reg_wdata[`TIU_C_RUN_B];
      end
      // A trigger both restarts and starts the counter.
      if (ld_b) begin
         cnt_b_nxt = init_b_r;
         psc_b_nxt = div_b - `TIU_PSC_ONE;
         run_b_nxt = trig_b || run_b_nxt;
      end
   end

   // Timer state; reset leaves both counters stopped.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_a_r <= `TIU_RST8;
         cnt_b_r <= `TIU_RST8;
         psc_a_r <= `TIU_RST6;
         psc_b_r <= `TIU_RST6;
         run_a_r <= 1'b0;
         run_b_r <= 1'b0;
         div4_r <= `TIU_RST2;
      end else begin
         cnt_a_r <= cnt_a_nxt;
         cnt_b_r <= cnt_b_nxt;
         psc_a_r <= psc_a_nxt;
         psc_b_r <= psc_b_nxt;
         run_a_r <= run_a_nxt;
         run_b_r <= run_b_nxt;
         div4_r <= div4_r + `TIU_DIV4_ONE;
      end
   end

   // Software configuration registers.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         init_a_r <= `TIU_RST8;
         init_b_r <= `TIU_RST8;
         psc_cfg_a_r <= `TIU_RST8;
         psc_cfg_b_r <= `TIU_RST8;
         tin_mode_r <= `TIU_RST2;
         casc_r <= 1'b0;
         mask_r <= `TIU_RST6;
         prio_r <= `TIU_RST3;
         es_r <= `TIU_RST2;
      end else begin
         if (wr_ta_cnt) init_a_r <= reg_wdata;
         if (wr_tb_cnt) init_b_r <= reg_wdata;
         if (wr_ta_psc) psc_cfg_a_r <= reg_wdata;
         if (wr_tb_psc) psc_cfg_b_r <= reg_wdata;
         if (wr_ctrl) tin_mode_r <= reg_wdata[`TIU_C_TIN_HI:`TIU_C_TIN_LO];
         if (wr_ctrl) casc_r <= reg_wdata[`TIU_C_CASC];
         if (wr_mask) mask_r <= reg_wdata[`TIU_REQ_HI:0];
         if (wr_prio) prio_r <= reg_wdata[2:0];
         if (wr_req) es_r <= reg_wdata[`TIU_ES_HI:`TIU_ES_LO];
      end
   end

////////////////////////////////////////////////////////////////////////////////////////////////
// Request capture.

   // Previous input levels: {uart, port c, port a, rx pin, timer pin, any-edge pin, fall pin}.
   wire [6:0] in_now = {uart_irq, port_c_data_avail, port_a_data_avail, pin_rx_irq,
                        pin_timer_irq, pin_any_edge_irq, pin_fall_irq};
   wire [6:0] rise = in_now & ~prev_r;
   wire [6:0] fall = ~in_now & prev_r;
   // Edge sense of the timer pin and the any-edge pin from the top request bits.
   wire es_both = es_r == `TIU_ES_BOTH;
   wire ev_p31 = es_both ? (tin_rise || tin_fall) : (es_r[1] ? tin_rise : tin_fall);
   wire ev_p32 = es_both ? (rise[1] || fall[1]) : (es_r[0] ? rise[1] : fall[1]);
   // Six sources: four pin requests, three of them with side sources, then the two timers.
   wire [5:0] ev = {eoc_b, eoc_a, fall[3] || rise[6], ev_p31 || rise[5], fall[0], ev_p32 || rise[4]};
   // Only the granted request is cleared by the interrupt cycle.
   wire [5:0] grant_clr = (state_r == tiu_pkg::TIU_DIS) ? (6'h01 << idx_r) : `TIU_RST6;

   // Events latch regardless of mask, and a new event beats a clear in the same cycle.
   always_comb begin
      pend_nxt = ((wr_req ? reg_wdata[`TIU_REQ_HI:0] : pend_r) & ~grant_clr) | ev;
      glob_en_nxt = wr_mask ? reg_wdata[`TIU_MASK_GLB] : glob_en_r;
      if (state_r == tiu_pkg::TIU_DIS) begin
         glob_en_nxt = 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////////////////////
// Priority and interrupt cycle.

   // Individual enables gate the requests offered to the encoder; the global enable gates only the grant.
   wire [5:0] masked = pend_r & mask_r;
   wire [3:0] pick = tiu_pick(masked, prio_r);
   wire [15:0] vec_w = {`TIU_VEC_PAD, idx_r, 1'b0};

   // Sequencer: disable, save context, fetch two vector bytes, branch.
   always_comb begin
      case (state_r)
         tiu_pkg::TIU_IDLE: state_nxt = (glob_en_r && pick[3] && cpu_int_ok) ? tiu_pkg::TIU_DIS : tiu_pkg::TIU_IDLE;
         tiu_pkg::TIU_DIS: state_nxt = tiu_pkg::TIU_SAVE;
         tiu_pkg::TIU_SAVE: state_nxt = tiu_pkg::TIU_HI;
         tiu_pkg::TIU_HI: state_nxt = tiu_pkg::TIU_LO;
         tiu_pkg::TIU_LO: state_nxt = tiu_pkg::TIU_BR;
         default: state_nxt = tiu_pkg::TIU_IDLE;
      endcase
   end

   // Interrupt state; reset clears requests and leaves interrupts globally off.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= tiu_pkg::TIU_IDLE;
         pend_r <= `TIU_RST6;
         glob_en_r <= 1'b0;
         idx_r <= `TIU_RST3;
         prev_r <= `TIU_IN_IDLE; // Idle levels, so no false edge follows reset.
         vec_hi_r <= `TIU_RST8;
      end else begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
         glob_en_r <= glob_en_nxt;
         prev_r <= in_now;
         if (state_r == tiu_pkg::TIU_IDLE) idx_r <= pick[2:0];
         if (state_r == tiu_pkg::TIU_LO) vec_hi_r <= pm_data;
      end
   end

   // Registered outputs; read data stands only in the cycle after the strobe.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `TIU_RST8;
         save_ctx <= 1'b0;
         pm_rd <= 1'b0;
         pm_addr <= 16'h0000;
         branch <= 1'b0;
         branch_addr <= 16'h0000;
         wake <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : `TIU_RST8;
         save_ctx <= state_r == tiu_pkg::TIU_DIS;
         pm_rd <= state_r == tiu_pkg::TIU_SAVE || state_r == tiu_pkg::TIU_HI;
         pm_addr <= (state_r == tiu_pkg::TIU_HI) ? (vec_w | 16'h0001) : vec_w;
         branch <= state_r == tiu_pkg::TIU_BR;
         if (state_r == tiu_pkg::TIU_BR) branch_addr <= {vec_hi_r, pm_data};
         wake <= |masked;
      end
   end

////////////////////////////////////////////////////////////////////////////////////////////////
// Checks.

   property p_glob_off;
      @(posedge ref_clk) disable iff (!rst_b) state_r == tiu_pkg::TIU_DIS |=> !glob_en_r;
   endproperty
   a_glob_off: assert property (p_glob_off) else $error("global enable stayed on after grant");
   property p_seq;
      @(posedge ref_clk) disable iff (!rst_b)
         state_r == tiu_pkg::TIU_DIS |=> save_ctx && !pm_rd ##1 pm_rd ##1 pm_rd ##1 !pm_rd ##1 branch;
   endproperty
   a_seq: assert property (p_seq) else $error("interrupt cycle out of order");
   property p_vec_addr;
      @(posedge ref_clk) disable iff (!rst_b) state_r == tiu_pkg::TIU_HI |-> pm_addr == {`TIU_VEC_PAD, idx_r, 1'b0};
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address");
   property p_vec_data;
      @(posedge ref_clk) disable iff (!rst_b) branch |-> branch_addr == {$past(pm_data, 2), $past(pm_data, 1)};
   endproperty
   a_vec_data: assert property (p_vec_data) else $error("wrong service address");
   property p_masked;
      @(posedge ref_clk) disable iff (!rst_b) state_r == tiu_pkg::TIU_IDLE && !glob_en_r |=> state_r != tiu_pkg::TIU_DIS;
   endproperty
   a_masked: assert property (p_masked) else $error("grant while globally disabled");
   property p_poll;
      @(posedge ref_clk) disable iff (!rst_b) fall[0] |=> pend_r[1];
   endproperty
   a_poll: assert property (p_poll) else $error("request not latched");
   property p_eoc_req;
      @(posedge ref_clk) disable iff (!rst_b) eoc_a |=> pend_r[`TIU_REQ_TA];
   endproperty
   a_eoc_req: assert property (p_eoc_req) else $error("timer request missing");
   property p_single;
      @(posedge ref_clk) disable iff (!rst_b)
         eoc_a && !psc_cfg_a_r[`TIU_PSC_RELOAD] && !wr_ctrl |=> !run_a_r && cnt_a_r == `TIU_RST8;
   endproperty
   a_single: assert property (p_single) else $error("single pass did not halt");
   property p_reload;
      @(posedge ref_clk) disable iff (!rst_b) eoc_b && psc_cfg_b_r[`TIU_PSC_RELOAD] |=> cnt_b_r == $past(init_b_r);
   endproperty
   a_reload: assert property (p_reload) else $error("reload value wrong");
   property p_read;
      @(posedge ref_clk) disable iff (!rst_b) reg_rd && reg_addr == `TIU_ADR_TA_CNT |=> reg_rdata == $past(cnt_a_r);
   endproperty
   a_read: assert property (p_read) else $error("counter read back wrong");
   // With the source pulsing every fourth clock, a divisor of two leaves seven idle cycles between ticks.
   property p_div2;
      @(posedge ref_clk) disable iff (!rst_b) tick_a && div_a == 6'h02 |=> !tick_a [*7];
   endproperty
   a_div2: assert property (p_div2) else $error("prescaler ticked too soon");

   c_grant: cover property (@(posedge ref_clk) disable iff (!rst_b) branch);
   c_casc: cover property (@(posedge ref_clk) disable iff (!rst_b) casc_r && eoc_b);
   c_trig: cover property (@(posedge ref_clk) disable iff (!rst_b) trig_b);
   c_both: cover property (@(posedge ref_clk) disable iff (!rst_b) eoc_a && eoc_b);
endmodule

/* tb/tiu_core_model.sv */
// Core-side model: answers vector byte reads and offers interrupt cycles.
// Assumes the unit drives pm_rd and pm_addr off ref_clk.
`timescale 1ns/10ps
module tiu_core_model (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Program memory port.
   input wire logic pm_rd,
   input wire logic [15:0] pm_addr,
   output logic [7:0] pm_data,
   // Core readiness.
   output logic cpu_int_ok
);
   ////////////////////////////////////////////////////////////////////////////
   // Vector byte k holds 0x30+k; a released bus toggles so stale data shows.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pm_data <= 8'h00;
         cpu_int_ok <= 1'b0;
      end else begin
         cpu_int_ok <= 1'b1;
         if (pm_rd && pm_addr < 16'h000c) begin
            pm_data <= 8'h30 + pm_addr[7:0];
         end else begin
            pm_data <= ~pm_data;
         end
      end
   end
endmodule

/* tb/tb_tiu_top.sv */
// Self-checking bench of the timer and interrupt unit.
// Assumes the core model answers vector reads one cycle after pm_rd.
`timescale 1ns/10ps
module tb_tiu_top;
   logic ref_clk, rst_b, reg_wr, reg_rd, cpu_int_ok, save_ctx, pm_rd, branch, wake;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pm_data, v1, v2;
   logic [15:0] pm_addr, branch_addr;
   logic pin_rx_irq, pin_timer_irq, pin_any_edge_irq, pin_fall_irq;
   logic port_a_data_avail, port_c_data_avail, uart_irq;
   int err_count, check_count;
   tiu_top u_tiu_top (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pin_rx_irq, .pin_timer_irq, .pin_any_edge_irq, .pin_fall_irq, .port_a_data_avail,
      .port_c_data_avail, .uart_irq, .cpu_int_ok, .save_ctx, .pm_rd, .pm_addr, .pm_data,
      .branch, .branch_addr, .wake);
   tiu_core_model u_tiu_core_model (.ref_clk, .rst_b, .pm_rd, .pm_addr, .pm_data, .cpu_int_ok);
   ////////////////////////////////////////////////////////////////////////////
   // Clock at 100 MHz.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task pins(input logic [3:0] v);
      @(posedge ref_clk);
      {pin_rx_irq, pin_timer_irq, pin_any_edge_irq, pin_fall_irq} <= v;
      cyc(3);
   endtask
   // Waits a bounded time for the branch; request n vectors through bytes 2n and 2n+1.
   task take(input int n);
      int i;
      i = 0;
      do begin
         @(posedge ref_clk);
         #1 i++;
      end while (branch !== 1'b1 && i < 20);
      chk(branch, 1'b1);
      chk(branch_addr, {8'h30 + 8'(2 * n), 8'h31 + 8'(2 * n)});
   endtask
   task results;
      $display("errors=%0d checks=%0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the roughly five hundred cycles the sequence needs.
   initial begin
      #100000;
      err_count++;
      results();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {pin_rx_irq, pin_timer_irq, pin_any_edge_irq, pin_fall_irq} = 4'hf;
      {port_a_data_avail, port_c_data_avail, uart_irq} = 3'h0;
      err_count = 0;
      check_count = 0;
      cyc(4);
      rst_b <= 1'b1;
      rd(8'h01, v1); chk(v1, 8'h00);
      rd(8'h07, v1); chk(v1, 8'h00);
      rd(8'h20, v1); chk(v1, 8'h00);
      // Timer a single pass, divide by one, three steps.
      wr(8'h03, 8'h04);
      wr(8'h02, 8'h03);
      wr(8'h01, 8'h03);
      cyc(40);
      rd(8'h02, v1); chk(v1, 8'h00);
      rd(8'h01, v1); chk(v1, 8'h00);
      rd(8'h06, v1); chk(v1, 8'h10);
      // Reload keeps running; a stopped count reads back unchanged.
      wr(8'h03, 8'h05);
      wr(8'h01, 8'h03);
      cyc(40);
      rd(8'h01, v1); chk(v1, 8'h02);
      wr(8'h01, 8'h00);
      rd(8'h02, v1);
      cyc(20);
      rd(8'h02, v2); chk(v2, v1);
      rd(8'h03, v1); chk(v1, 8'h00);
      // Interrupt cycle for the timer a request.
      wr(8'h07, 8'h90);
      take(4);
      rd(8'h06, v1); chk(v1, 8'h00);
      rd(8'h07, v1); chk(v1, 8'h10);
      for (int n = 0; n < 6; n++) begin
         wr(8'h06, 8'(1 << n));
         wr(8'h07, 8'h80 | 8'(1 << n));
         take(n);
      end
      // Rotating priority starting at request two.
      wr(8'h08, 8'h02);
      wr(8'h06, 8'h05);
      wr(8'h07, 8'hbf);
      take(2);
      rd(8'h06, v1); chk(v1, 8'h01);
      wr(8'h07, 8'hbf);
      take(0);
      // Masked pin events still latch for polling.
      wr(8'h07, 8'h00);
      wr(8'h06, 8'h00);
      pins(4'h0);
      rd(8'h06, v1); chk(v1, 8'h0f);
      wr(8'h06, 8'h40);
      pins(4'hf);
      rd(8'h06, v1); chk(v1, 8'h41);
      wr(8'h06, 8'h00);
      {port_a_data_avail, port_c_data_avail, uart_irq} <= 3'h7;
      cyc(3);
      rd(8'h06, v1); chk(v1, 8'h0d);
      wr(8'h07, 8'h01);
      cyc(2);
      chk(wake, 1'b1);
      // Timer b clocked by three falls of the timer pin.
      wr(8'h06, 8'h00);
      wr(8'hf3, 8'h04);
      wr(8'h04, 8'h03);
      wr(8'h01, 8'h0c);
      repeat (3) begin
         pins(4'hb);
         pins(4'hf);
      end
      rd(8'h04, v1); chk(v1, 8'h00);
      rd(8'h06, v1); chk(v1, 8'h24);
      // Cascade: timer a (divide by two, four steps) clocks timer b (three steps, reload).
      wr(8'h06, 8'h00);
      wr(8'h03, 8'h09);
      wr(8'h02, 8'h04);
      wr(8'hf3, 8'h05);
      wr(8'h01, 8'h4f);
      cyc(40);
      rd(8'h04, v1); chk(v1, 8'h02);
      cyc(60);
      rd(8'h04, v1); chk(v1, 8'h03);
      rd(8'h01, v1); chk(v1, 8'h4a);
      rd(8'h06, v1); chk(v1, 8'h30);
      // One-shot trigger, then gate: timer b counts the internal clock.
      wr(8'hf3, 8'h04);
      wr(8'h01, 8'h20);
      wr(8'h06, 8'h00);
      pins(4'hb);
      pins(4'hf);
      cyc(20);
      rd(8'h06, v1); chk(v1, 8'h24);
      rd(8'h01, v1); chk(v1, 8'h20);
      wr(8'h01, 8'h10);
      pins(4'hb);
      wr(8'h01, 8'h1c);
      cyc(20);
      rd(8'h04, v1); chk(v1, 8'h03);
      pins(4'hf);
      cyc(20);
      rd(8'h04, v1); chk(v1, 8'h00);
      results();
   end
endmodule
